// ---- pkg/hpsr_consts.vh ----
`ifndef HPSR_CONSTS_VH
`define HPSR_CONSTS_VH
// ----------------------------------------
// bus styles and field widths
// ----------------------------------------
`define HPSR_STYLE_MOT_MUX     3'h1
`define HPSR_STYLE_MOT_NONMUX  3'h2
`define HPSR_STYLE_RDWR_MUX    3'h4
`define HPSR_ADDR_W            8
`define HPSR_DATA_W            16
`define HPSR_BYTE_W            8
// ----------------------------------------
// access states (one-hot)
// ----------------------------------------
`define HPSR_ST_IDLE           4'h1
`define HPSR_ST_READ           4'h2
`define HPSR_ST_WRITE          4'h4
`define HPSR_ST_ACK            4'h8
// ----------------------------------------
// timing
// ----------------------------------------
`define HPSR_CLK_PERIOD_NS     50
`define HPSR_RESET_MIN_NS      100
`define HPSR_RESET_MIN_CYC     ((`HPSR_RESET_MIN_NS + `HPSR_CLK_PERIOD_NS - 1) / `HPSR_CLK_PERIOD_NS)
`define HPSR_ZERO8             8'h00
`define HPSR_ZERO16            16'h0000
`endif

// ---- rtl/hpsr_sync2.v ----
`timescale 1ns/1ns
// ----------------------------------------
// two-stage synchroniser, one per bit
// ----------------------------------------
module hpsr_sync2 #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         reset,
    input  wire         ce,
    input  wire [W-1:0] din,
    output reg  [W-1:0] dout
);
    reg [W-1:0] meta_q;

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_q <= {W{1'b0}};
            dout   <= {W{1'b0}};
        end else if (ce) begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule // hpsr_sync2

// ---- rtl/hpsr_host_port.v ----
// Behaviour
// RULE1: reset clears all counters and registers; the reset pin leaves mem_addr and mem_wdata holding their values
// RULE2: reset floats serial outputs and data
// RULE3: host holds reset low at least 100ns
// RULE4: non-multiplexed uses dedicated address inputs
// RULE5: multiplexed strobe active high with select
// RULE6: non-multiplexed strobe active low with select
// RULE7: read strobe low drives both bytes
// RULE8: read/write input sets direction
// RULE9: write strobe low makes low byte input
// RULE10: mode input high means multiplexed
// RULE11: port active only with chip select
// RULE12: multiplexed address latched from low byte
// RULE13: acknowledge drives high then releases
// RULE14: no access or acknowledge during reset
`timescale 1ns/1ns
`include "hpsr_consts.vh"
module hpsr_host_port (
    clk,
    reset,
    ce,
    reset_n_pin,
    chip_select_n,
    host_interface_mode_select,
    rdwr_style_select,
    data_strobe_or_read_strobe,
    read_write_or_write_strobe,
    address_latch_strobe,
    direct_address_inputs,
    low_data_byte_lines_in,
    low_data_byte_lines_out,
    low_data_byte_lines_oe,
    high_data_byte_lines_in,
    high_data_byte_lines_out,
    high_data_byte_lines_oe,
    transfer_acknowledge_out,
    transfer_acknowledge_oe,
    serial_output_streams_oe,
    device_reset,
    mem_addr,
    mem_wr,
    mem_wdata,
    mem_rd,
    mem_rdata
);
    input  wire        clk;
    input  wire        reset;
    input  wire        ce;
    input  wire        reset_n_pin;
    input  wire        chip_select_n;
    input  wire        host_interface_mode_select;
    input  wire        rdwr_style_select;
    input  wire        data_strobe_or_read_strobe;
    input  wire        read_write_or_write_strobe;
    input  wire        address_latch_strobe;
    input  wire [7:0]  direct_address_inputs;
    input  wire [7:0]  low_data_byte_lines_in;
    output wire [7:0]  low_data_byte_lines_out;
    output wire        low_data_byte_lines_oe;
    input  wire [7:0]  high_data_byte_lines_in;
    output wire [7:0]  high_data_byte_lines_out;
    output wire        high_data_byte_lines_oe;
    output wire        transfer_acknowledge_out;
    output wire        transfer_acknowledge_oe;
    output wire        serial_output_streams_oe;
    output wire        device_reset;
    output reg  [7:0]  mem_addr;
    output reg         mem_wr;
    output reg  [15:0] mem_wdata;
    output reg         mem_rd;
    input  wire [15:0] mem_rdata;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    wire [30:0] sync_o;
    hpsr_sync2 #(.W(31)) u_sync (
        .clk   (clk),
        .reset (reset),
        .ce    (ce),
        .din   ({reset_n_pin, chip_select_n, host_interface_mode_select, rdwr_style_select,
                 data_strobe_or_read_strobe, read_write_or_write_strobe, address_latch_strobe,
                 direct_address_inputs, low_data_byte_lines_in, high_data_byte_lines_in}),
        .dout  (sync_o)
    );
    wire       rst_n_s = sync_o[30];
    wire       cs_n_s  = sync_o[29];
    wire       mode_s  = sync_o[28];
    wire       rdwr_s  = sync_o[27];
    wire       stb_s   = sync_o[26];
    wire       rw_s    = sync_o[25];
    wire       latch_s = sync_o[24];
    wire [7:0] adr_s   = sync_o[23:16];
    wire [7:0] lo_s    = sync_o[15:8];
    wire [7:0] hi_s    = sync_o[7:0];

    // ----------------------------------------
    // device reset held while the pin is low
    // ----------------------------------------
    // the pin is filtered by the synchroniser; the host must keep it low long enough
    reg dev_rst_q;
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            dev_rst_q <= 1'b1;
        end else if (ce) begin
            dev_rst_q <= ~rst_n_s; // RULE3
        end
    end
    assign device_reset = dev_rst_q | reset;

    // ----------------------------------------
    // strobe decode
    // ----------------------------------------
    wire sel = ~cs_n_s & ~device_reset; // RULE11 RULE14
    wire mux = mode_s; // RULE10
    wire [2:0] style = ~mux ? `HPSR_STYLE_MOT_NONMUX :
                       (rdwr_s ? `HPSR_STYLE_RDWR_MUX : `HPSR_STYLE_MOT_MUX);
    reg  acc_rd;
    reg  acc_wr;
    always @* begin
        acc_rd = 1'b0;
        acc_wr = 1'b0;
        case (style)
            `HPSR_STYLE_MOT_MUX: begin
                acc_rd = sel & stb_s & rw_s; // RULE5 RULE8
                acc_wr = sel & stb_s & ~rw_s; // RULE5 RULE8
            end
            `HPSR_STYLE_MOT_NONMUX: begin
                acc_rd = sel & ~stb_s & rw_s; // RULE6 RULE8
                acc_wr = sel & ~stb_s & ~rw_s; // RULE6 RULE8
            end
            `HPSR_STYLE_RDWR_MUX: begin
                acc_rd = sel & ~stb_s; // RULE7
                acc_wr = sel & ~rw_s & stb_s; // RULE9
            end
            default: begin
                acc_rd = 1'b0;
                acc_wr = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // access sequencer
    // ----------------------------------------
    reg [3:0]  state_q;
    reg [7:0]  lat_addr_q;
    reg [15:0] rdata_q;
    reg        drive_q;
    reg        ack_q;
    reg        ack_oe_q;
    wire [7:0] cur_addr = mux ? lat_addr_q : adr_s; // RULE4 RULE12

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q    <= `HPSR_ST_IDLE;
            lat_addr_q <= `HPSR_ZERO8;
            rdata_q    <= `HPSR_ZERO16;
            drive_q    <= 1'b0;
            ack_q      <= 1'b0;
            ack_oe_q   <= 1'b0;
            mem_addr   <= `HPSR_ZERO8;
            mem_wr     <= 1'b0;
            mem_wdata  <= `HPSR_ZERO16;
            mem_rd     <= 1'b0;
        end else if (ce) begin
            mem_wr <= 1'b0;
            mem_rd <= 1'b0;
            if (dev_rst_q) begin
                state_q    <= `HPSR_ST_IDLE; // RULE1 RULE14
                lat_addr_q <= `HPSR_ZERO8;
                rdata_q    <= `HPSR_ZERO16;
                drive_q    <= 1'b0;
                ack_q      <= 1'b0;
                ack_oe_q   <= 1'b0;
            end else begin
                if (mux && latch_s && !cs_n_s) begin
                    lat_addr_q <= lo_s; // RULE12
                end
                case (state_q)
                    `HPSR_ST_IDLE: begin
                        ack_q    <= 1'b0;
                        ack_oe_q <= 1'b0;
                        if (acc_rd) begin
                            mem_addr <= cur_addr;
                            mem_rd   <= 1'b1;
                            state_q  <= `HPSR_ST_READ;
                        end else if (acc_wr) begin
                            mem_addr  <= cur_addr;
                            mem_wr    <= 1'b1;
                            // the read/write-strobe style takes only the low byte and writes zero to the high byte
                            mem_wdata <= (style == `HPSR_STYLE_RDWR_MUX) ? {`HPSR_ZERO8, lo_s} : {hi_s, lo_s}; // RULE9
                            state_q   <= `HPSR_ST_WRITE;
                        end
                    end
                    `HPSR_ST_READ: begin
                        rdata_q <= mem_rdata;
                        drive_q <= 1'b1;
                        if (!acc_rd) begin
                            state_q <= `HPSR_ST_ACK;
                        end
                    end
                    `HPSR_ST_WRITE: begin
                        if (!acc_wr) begin
                            state_q <= `HPSR_ST_ACK;
                        end
                    end
                    `HPSR_ST_ACK: begin
                        drive_q  <= 1'b0;
                        ack_q    <= 1'b1; // RULE13
                        ack_oe_q <= 1'b1;
                        state_q  <= `HPSR_ST_IDLE;
                    end
                    default: begin
                        state_q <= `HPSR_ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // pad drivers
    // ----------------------------------------
    // drivers gated combinationally by reset so the pins float without waiting a clock
    wire drv = drive_q & acc_rd & ~device_reset; // RULE2 RULE7 RULE8
    assign low_data_byte_lines_out  = rdata_q[7:0];
    assign high_data_byte_lines_out = rdata_q[15:8];
    assign low_data_byte_lines_oe   = drv;
    assign high_data_byte_lines_oe  = drv;
    assign transfer_acknowledge_out = ack_q;
    assign transfer_acknowledge_oe  = ack_oe_q & ~device_reset; // RULE13 RULE14
    assign serial_output_streams_oe = ~device_reset; // RULE2
endmodule // hpsr_host_port

// ---- sim/hpsr_mem_model.sv ----
`timescale 1ns/1ns
module hpsr_mem_model (
    input  wire        clk,
    input  wire [7:0]  mem_addr,
    input  wire        mem_wr,
    input  wire [15:0] mem_wdata,
    output wire [15:0] mem_rdata
);
    reg [15:0] m [0:255];
    // unwritten words read as unknown, so a stray read can never match
    always @(posedge clk) if (mem_wr) m[mem_addr] <= mem_wdata;
    assign mem_rdata = m[mem_addr];
endmodule // hpsr_mem_model

// ---- sim/hpsr_host_port_props.sv ----
`timescale 1ns/1ns
module hpsr_props (
    input wire clk,
    input wire reset,
    input wire chip_select_n,
    input wire low_data_byte_lines_oe,
    input wire high_data_byte_lines_oe,
    input wire transfer_acknowledge_out,
    input wire transfer_acknowledge_oe,
    input wire serial_output_streams_oe,
    input wire device_reset,
    input wire mem_wr,
    input wire mem_rd
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // past guard: the edge on which device reset rises may still show old outputs
    chk_data_float: assert property (device_reset && $past(device_reset) |-> !low_data_byte_lines_oe)
        else $error("data driven in reset");
    chk_stream_float: assert property (device_reset && $past(device_reset) |-> !serial_output_streams_oe)
        else $error("streams driven in reset");
    chk_no_ack_rst: assert property (device_reset && $past(device_reset) |-> !transfer_acknowledge_oe)
        else $error("ack in reset");
    chk_no_mem_rst: assert property (device_reset && $past(device_reset) |-> !mem_rd && !mem_wr)
        else $error("access in reset");
    chk_ack_pulse: assert property ($rose(transfer_acknowledge_oe) |-> transfer_acknowledge_out ##1 !transfer_acknowledge_oe)
        else $error("ack not one high cycle");
    chk_cs_gate: assert property (chip_select_n [*5] |-> !mem_rd && !mem_wr)
        else $error("access without select");
    chk_byte_pair: assert property (low_data_byte_lines_oe == high_data_byte_lines_oe)
        else $error("byte enables differ");
    chk_write_in: assert property (mem_wr |-> !low_data_byte_lines_oe)
        else $error("driving during write");
    cover property (mem_rd);
    cover property (mem_wr);
    cover property ($rose(transfer_acknowledge_oe));
endmodule // hpsr_props
bind hpsr_host_port hpsr_props u_props (.clk, .reset, .chip_select_n, .low_data_byte_lines_oe,
    .high_data_byte_lines_oe, .transfer_acknowledge_out, .transfer_acknowledge_oe,
    .serial_output_streams_oe, .device_reset, .mem_wr, .mem_rd);

// ---- sim/testbench.sv ----
`timescale 1ns/1ns
module testbench;
    reg         clk = 0, reset = 1, ce = 1, rst_n = 1, cs_n = 1, mode_sel = 0, sty = 0, dstb = 1, rw = 1;
    reg         alat = 0;
    reg  [7:0]  a = 8'h00, lo = 8'h00, hi = 8'h00;
    wire [7:0]  lo_o, hi_o, maddr;
    wire        lo_oe, hi_oe, ack_o, ack_oe, so_oe, dres, mwr, mrd;
    wire [15:0] mwd, mrdt;
    integer     num_errors = 0, num_checks = 0, acks = 0;
    always #25 clk = ~clk;
    always @(posedge clk) if (ack_oe === 1'b1) acks = acks + 1;
    hpsr_host_port dut (.clk(clk), .reset(reset), .ce(ce), .reset_n_pin(rst_n), .chip_select_n(cs_n),
        .host_interface_mode_select(mode_sel), .rdwr_style_select(sty), .data_strobe_or_read_strobe(dstb),
        .read_write_or_write_strobe(rw), .address_latch_strobe(alat), .direct_address_inputs(a),
        .low_data_byte_lines_in(lo), .low_data_byte_lines_out(lo_o), .low_data_byte_lines_oe(lo_oe),
        .high_data_byte_lines_in(hi), .high_data_byte_lines_out(hi_o), .high_data_byte_lines_oe(hi_oe),
        .transfer_acknowledge_out(ack_o), .transfer_acknowledge_oe(ack_oe), .serial_output_streams_oe(so_oe),
        .device_reset(dres), .mem_addr(maddr), .mem_wr(mwr), .mem_wdata(mwd), .mem_rd(mrd), .mem_rdata(mrdt));
    hpsr_mem_model host_mem (.clk(clk), .mem_addr(maddr), .mem_wr(mwr), .mem_wdata(mwd), .mem_rdata(mrdt));
    task cyc(input integer n); begin repeat (n) @(posedge clk); #5; end endtask
    task stop_test; begin
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    end endtask
    task ck(input [15:0] g, input [15:0] e); begin
        num_checks = num_checks + 1;
        if (g !== e) begin
            num_errors = num_errors + 1;
            $display("Error t=%0t got %h exp %h", $time, g, e);
        end
    end endtask
    // m: 0 strobe-high multiplexed, 1 non-multiplexed, 2 read/write-strobe multiplexed
    task ac(input [1:0] m, input wr, input [7:0] ad, input [15:0] d);
        integer i;
        begin
            mode_sel = m != 2'h1;
            sty = m == 2'h2;
            dstb = m != 2'h0;
            rw = 1;
            a = ad;
            lo = ad;
            alat = m != 2'h1;
            cs_n = 0;
            cyc(4);
            alat = 0;
            {hi, lo} = d;
            rw = !wr;
            dstb = m == 2'h0 || (m == 2'h2 && wr);
            if (wr) cyc(8);
            for (i = 0; i < 20 && !wr && lo_oe !== 1'b1; i = i + 1) cyc(1);
            ck({hi_oe, lo_oe}, {2{!wr}});
            if (!wr) ck({hi_o, lo_o}, d);
            if (!wr && lo_oe !== 1'b1) stop_test;
            dstb = m != 2'h0;
            rw = 1;
            for (i = 0; i < 10 && ack_oe !== 1'b1; i = i + 1) cyc(1);
            ck(ack_o, 1'b1);
            if (ack_oe !== 1'b1) stop_test;
            cs_n = 1;
            cyc(1);
            ck(ack_oe, 1'b0);
        end
    endtask
    task t_modes;
        reg [1:0] m;
        begin
            for (m = 0; m < 3; m = m + 1) begin
                ac(m, 1, {6'h04, m}, {14'h2970, m});
                ac(m, 0, {6'h04, m}, m == 2 ? 16'h00C2 : {14'h2970, m});
            end
            ac(1, 1, 8'h3C, 16'h1234);
            ac(0, 0, 8'h3C, 16'h1234);
        end
    endtask
    task t_cs;
        integer n;
        begin
            n = acks;
            mode_sel = 0;
            a = 8'h3C;
            {hi, lo} = 16'hDEAD;
            rw = 0;
            dstb = 0;
            cyc(10);
            dstb = 1;
            rw = 1;
            cyc(6);
            ck(acks - n, 16'h0000);
            ac(1, 0, 8'h3C, 16'h1234);
        end
    endtask
    // a read held while the clock enable is low must wait, then finish once enabled
    task t_ce;
        integer i;
        begin
            ce = 0;
            mode_sel = 0;
            a = 8'h3C;
            rw = 1;
            dstb = 0;
            cs_n = 0;
            cyc(6);
            ck({mrd, lo_oe}, 16'h0000);
            ce = 1;
            for (i = 0; i < 20 && lo_oe !== 1'b1; i = i + 1) cyc(1);
            ck({hi_o, lo_o}, 16'h1234);
            if (lo_oe !== 1'b1) stop_test;
            dstb = 1;
            for (i = 0; i < 10 && ack_oe !== 1'b1; i = i + 1) cyc(1);
            ck(ack_o, 1'b1);
            if (ack_oe !== 1'b1) stop_test;
            cs_n = 1;
            cyc(1);
        end
    endtask
    task t_rst;
        integer n;
        begin
            n = acks;
            mode_sel = 0;
            cs_n = 0;
            dstb = 0;
            cyc(2);
            rst_n = 0;
            cyc(4);
            ck({dres, so_oe, hi_oe, lo_oe}, 16'h0008);
            rst_n = 1;
            dstb = 1;
            cs_n = 1;
            cyc(6);
            ck(acks - n, 16'h0000);
            ck(dres, 1'b0);
            ac(1, 0, 8'h3C, 16'h1234);
        end
    endtask
    initial begin
        cyc(3);
        reset = 0;
        cyc(6);
        t_modes;
        t_cs;
        t_ce;
        t_rst;
        stop_test;
    end
endmodule // testbench
